/* File: ssf_pkg.sv */
// package for the segmented stream framer: register map, control byte layout, states
package ssf_pkg;

	// register byte addresses
	localparam logic [3:0] SSF_ADDR_MODE = 4'h0;
	localparam logic [3:0] SSF_ADDR_STATUS = 4'h4;

	// stream_packing_mode fields
	localparam int SSF_MODE_MULTI_BIT = 0;
	localparam int SSF_MODE_LONG_BIT = 1;
	localparam logic [7:0] SSF_MODE_RESET = 8'h00;
	localparam logic [7:0] SSF_MODE_MASK = 8'h03;

	// status register fields
	localparam int SSF_ST_SKIP_BIT = 0;
	localparam int SSF_ST_SYNC_BIT = 1;
	localparam int SSF_ST_TXSEQ_LSB = 8;
	localparam int SSF_ST_CONFIRM_LSB = 16;

	// control byte layout
	localparam int SSF_CB_FOLLOW_BIT = 6;
	localparam int SSF_CB_LAST_BIT = 7;
	localparam logic [7:0] SSF_IDLE_CONTROL_BYTE = 8'h00;
	localparam logic [6:0] SSF_LONG_SEG_MAX = 7'h3F;

	// axi responses
	localparam logic [1:0] SSF_RESP_OKAY = 2'h0;
	localparam logic [1:0] SSF_RESP_SLVERR = 2'h2;

	// upstream transmitter states
	typedef enum logic [4:0] {
		SSF_TX_RESYNC = 5'h01,
		SSF_TX_SYNCWAIT = 5'h02,
		SSF_TX_BUILD = 5'h04,
		SSF_TX_HOLD = 5'h08,
		SSF_TX_ACK = 5'h10
	} ssf_tx_state_type;

	// downstream receiver states
	typedef enum logic [1:0] {
		SSF_RX_IDLE = 2'h1,
		SSF_RX_PARSE = 2'h2
	} ssf_rx_state_type;

	// control byte as length plus follow-header and message-end flags
	function automatic logic [7:0] ssf_make_cb(input logic [5:0] len, input logic follow,
		input logic last);
		ssf_make_cb = {last, follow, len};
	endfunction

endpackage

/* File: ssf_framer.sv */
// segmented stream framer: upstream window builder, downstream parser, axi4-lite registers
//
// The implementer's own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/100ps

module ssf_framer
	import ssf_pkg::*;
#(
	parameter int WIN_BYTES = 8,
	parameter int AXI_ADDR_W = 4
)(
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// axi4-lite register slave
	input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// message source for the upstream direction
	input wire logic src_valid,
	output logic src_ready,
	input wire logic [7:0] src_data,
	input wire logic [15:0] src_remaining,
	output logic src_restart,
	// cyclic bus period marker
	input wire logic bus_tick,
	// upstream window towards the host
	output logic [WIN_BYTES*8-1:0] upstream_window,
	output logic [7:0] tx_seq_number,
	output logic up_sync_bit,
	input wire logic [7:0] host_seq_confirm,
	input wire logic host_up_sync_ack,
	// downstream window from the host
	input wire logic [WIN_BYTES*8-1:0] dn_window,
	input wire logic [7:0] dn_seq_number,
	input wire logic dn_sync_bit,
	output logic [7:0] rx_seq_confirm,
	output logic dn_sync_ack,
	// message sink for the downstream direction
	output logic snk_valid,
	input wire logic snk_ready,
	output logic [7:0] snk_data,
	output logic snk_last
);

	localparam logic [6:0] WIN_LEN = 7'(WIN_BYTES);

	// elaboration check: positions are 7 bits and lengths 6 bits
	if (WIN_BYTES < 2 || WIN_BYTES > 64 || AXI_ADDR_W < 4)
	begin : g_bad_param
		$error("ssf_framer: WIN_BYTES must be 2..64 and AXI_ADDR_W at least 4");
	end

	typedef struct packed {
		ssf_tx_state_type tst;
		logic [6:0] pos;
		logic [5:0] seg_rem;
		logic seg_end;
		logic [7:0] seq;
		logic up_sync;
		logic restart;
		logic [WIN_BYTES*8-1:0] tbuf;
		logic [WIN_BYTES*8-1:0] up_win;
		ssf_rx_state_type rst;
		logic [6:0] rpos;
		logic [5:0] rrem;
		logic rend;
		logic rfollow;
		logic [7:0] rlast;
		logic [7:0] rseq;
		logic [7:0] confirm;
		logic [WIN_BYTES*8-1:0] rwin;
		logic dn_ack;
		logic skip_sticky;
		logic [7:0] mode;
		logic aw_got;
		logic w_got;
		logic [AXI_ADDR_W-1:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} ssf_state_type;

	ssf_state_type state_reg;
	ssf_state_type state_next;

	// scratch values of the next-state logic
	logic multi_en;
	logic long_en;
	logic [6:0] space;
	logic [6:0] cap;
	logic fits;
	logic [5:0] seg_len;
	logic [7:0] ack_diff;
	logic [7:0] seq_diff;
	logic [7:0] rbyte;
	logic skip_event;
	logic [31:0] status_word;

	// downstream byte under the parse pointer
	assign rbyte = state_reg.rwin[state_reg.rpos[5:0]*8 +: 8];

	// handshakes are combinational, data straight from the state
	assign s_axi_awready = !state_reg.aw_got && !state_reg.bvalid;
	assign s_axi_wready = !state_reg.w_got && !state_reg.bvalid;
	assign s_axi_bvalid = state_reg.bvalid;
	assign s_axi_bresp = state_reg.bresp;
	assign s_axi_arready = !state_reg.rvalid;
	assign s_axi_rvalid = state_reg.rvalid;
	assign s_axi_rdata = state_reg.rdata;
	assign s_axi_rresp = state_reg.rresp;
	assign upstream_window = state_reg.up_win;
	assign tx_seq_number = state_reg.seq;
	assign up_sync_bit = state_reg.up_sync;
	assign src_restart = state_reg.restart;
	assign rx_seq_confirm = state_reg.confirm;
	assign dn_sync_ack = state_reg.dn_ack;
	assign src_ready = state_reg.tst == SSF_TX_BUILD && state_reg.pos != WIN_LEN
		&& state_reg.seg_rem != 6'h00;
	assign snk_valid = state_reg.rst == SSF_RX_PARSE && state_reg.rpos != WIN_LEN
		&& state_reg.rrem != 6'h00;
	assign snk_data = rbyte;
	assign snk_last = state_reg.rend && state_reg.rrem == 6'h01;

	// status word as software sees it
	assign status_word = {8'h00, state_reg.confirm, state_reg.seq, 6'h00,
		state_reg.tst == SSF_TX_BUILD || state_reg.tst == SSF_TX_HOLD
		|| state_reg.tst == SSF_TX_ACK, state_reg.skip_sticky};

	// all next-state logic of the block
	always_comb
	begin
		state_next = state_reg;
		state_next.restart = 1'b0;
		multi_en = state_reg.mode[SSF_MODE_MULTI_BIT];
		long_en = state_reg.mode[SSF_MODE_LONG_BIT];
		space = WIN_LEN - 7'h01 - state_reg.pos;
		// long segments ignore the window width; both options combine freely
		cap = long_en ? SSF_LONG_SEG_MAX : space;
		fits = src_remaining <= {9'h000, cap};
		seg_len = fits ? src_remaining[5:0] : cap[5:0];
		ack_diff = host_seq_confirm - state_reg.seq;
		seq_diff = dn_seq_number - state_reg.rlast;
		skip_event = 1'b0;

		// upstream transmitter
		case (state_reg.tst)
			SSF_TX_RESYNC:
			begin
				state_next.up_sync = 1'b0;
				if (!host_up_sync_ack)
				begin
					state_next.up_sync = 1'b1;
					state_next.tst = SSF_TX_SYNCWAIT;
				end
			end
			SSF_TX_SYNCWAIT:
			begin
				if (host_up_sync_ack)
				begin
					// carry on after the last sequence the host confirmed
					state_next.seq = host_seq_confirm;
					state_next.tst = SSF_TX_BUILD;
				end
			end
			SSF_TX_BUILD:
			begin
				if (state_reg.pos == WIN_LEN)
				begin
					state_next.tst = SSF_TX_HOLD;
				end
				else if (state_reg.seg_rem == 6'h00)
				begin
					if (state_reg.pos == 7'h00 && !src_valid)
					begin
						// nothing pending: keep the channel on standby
						state_next.tbuf[7:0] = SSF_IDLE_CONTROL_BYTE;
						state_next.tst = SSF_TX_HOLD;
					end
					else if (state_reg.pos == 7'h00
						|| (multi_en && src_valid && state_reg.pos <= WIN_LEN - 7'h02))
					begin
						// one control byte per segment, first byte when not continuing
						state_next.tbuf[state_reg.pos[5:0]*8 +: 8] =
							ssf_make_cb(seg_len, multi_en, fits);
						state_next.seg_rem = seg_len;
						state_next.seg_end = fits;
						state_next.pos = state_reg.pos + 7'h01;
					end
					else
					begin
						state_next.tst = SSF_TX_HOLD;
					end
				end
				else if (src_valid)
				begin
					state_next.tbuf[state_reg.pos[5:0]*8 +: 8] = src_data;
					state_next.seg_rem = state_reg.seg_rem - 6'h01;
					state_next.pos = state_reg.pos + 7'h01;
					// without multi-segment windows the tail stays empty
					if (state_reg.seg_rem == 6'h01 && !multi_en)
					begin
						state_next.tst = SSF_TX_HOLD;
					end
					// with it the loop goes on to the next control byte
				end
			end
			SSF_TX_HOLD:
			begin
				if (bus_tick)
				begin
					state_next.up_win = state_reg.tbuf;
					state_next.seq = state_reg.seq + 8'h01;
					state_next.tbuf = '0;
					state_next.pos = 7'h00;
					state_next.tst = SSF_TX_ACK;
				end
			end
			SSF_TX_ACK:
			begin
				if (!host_up_sync_ack || (ack_diff != 8'h00 && !ack_diff[7]))
				begin
					// sync ack lost or confirmation of an unsent sequence: drop message, resync
					state_next.restart = 1'b1;
					state_next.up_sync = 1'b0;
					state_next.seg_rem = 6'h00;
					state_next.tbuf = '0;
					state_next.tst = SSF_TX_RESYNC;
				end
				else if (ack_diff == 8'h00)
				begin
					state_next.tst = SSF_TX_BUILD;
				end
			end
			default:
			begin
				state_next.tst = SSF_TX_RESYNC;
			end
		endcase

		// downstream receiver, always accepts both packing options
		state_next.dn_ack = dn_sync_bit;
		case (state_reg.rst)
			SSF_RX_IDLE:
			begin
				if (!dn_sync_bit)
				begin
					state_next.rlast = dn_seq_number;
					state_next.confirm = dn_seq_number;
					state_next.rrem = 6'h00;
				end
				else if (bus_tick && seq_diff == 8'h01)
				begin
					state_next.rwin = dn_window;
					state_next.rseq = dn_seq_number;
					state_next.rpos = 7'h00;
					state_next.rst = SSF_RX_PARSE;
				end
				else if (bus_tick && seq_diff != 8'h00)
				begin
					// skipped sequence: ignore it until the expected one arrives
					skip_event = 1'b1;
				end
			end
			SSF_RX_PARSE:
			begin
				if (state_reg.rpos == WIN_LEN)
				begin
					// only a fully taken window is confirmed
					state_next.confirm = state_reg.rseq;
					state_next.rlast = state_reg.rseq;
					state_next.rst = SSF_RX_IDLE;
				end
				else if (state_reg.rrem == 6'h00)
				begin
					if (rbyte[5:0] == 6'h00)
					begin
						state_next.rpos = WIN_LEN;
					end
					else
					begin
						state_next.rrem = rbyte[5:0];
						state_next.rfollow = rbyte[SSF_CB_FOLLOW_BIT];
						state_next.rend = rbyte[SSF_CB_LAST_BIT];
						state_next.rpos = state_reg.rpos + 7'h01;
					end
				end
				else if (snk_ready)
				begin
					state_next.rrem = state_reg.rrem - 6'h01;
					state_next.rpos = state_reg.rpos + 7'h01;
					// no follow flag: rest of the window carries nothing
					if (state_reg.rrem == 6'h01 && !state_reg.rfollow)
					begin
						state_next.rpos = WIN_LEN;
					end
				end
			end
			default:
			begin
				state_next.rst = SSF_RX_IDLE;
			end
		endcase

		// axi write channel, address and data in either order
		if (s_axi_awvalid && s_axi_awready)
		begin
			state_next.aw_got = 1'b1;
			state_next.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			state_next.w_got = 1'b1;
			state_next.wdata = s_axi_wdata;
			state_next.wstrb = s_axi_wstrb;
		end
		if (state_reg.aw_got && state_reg.w_got)
		begin
			state_next.aw_got = 1'b0;
			state_next.w_got = 1'b0;
			state_next.bvalid = 1'b1;
			state_next.bresp = SSF_RESP_OKAY;
			if (state_reg.awaddr[3:0] == SSF_ADDR_MODE && state_reg.awaddr[AXI_ADDR_W-1:4] == '0)
			begin
				if (state_reg.wstrb[0])
				begin
					state_next.mode = state_reg.wdata[7:0] & SSF_MODE_MASK;
				end
			end
			else if (state_reg.awaddr[3:0] == SSF_ADDR_STATUS
				&& state_reg.awaddr[AXI_ADDR_W-1:4] == '0)
			begin
				if (state_reg.wstrb[0] && state_reg.wdata[SSF_ST_SKIP_BIT])
				begin
					state_next.skip_sticky = 1'b0;
				end
			end
			else
			begin
				state_next.bresp = SSF_RESP_SLVERR;
			end
		end
		else if (state_reg.bvalid && s_axi_bready)
		begin
			state_next.bvalid = 1'b0;
		end

		// a skip in the same cycle as its clear still sticks
		if (skip_event)
		begin
			state_next.skip_sticky = 1'b1;
		end

		// axi read channel, answer one cycle after the address
		if (s_axi_arvalid && !state_reg.rvalid)
		begin
			state_next.rvalid = 1'b1;
			state_next.rresp = SSF_RESP_OKAY;
			if (s_axi_araddr[3:0] == SSF_ADDR_MODE && s_axi_araddr[AXI_ADDR_W-1:4] == '0)
			begin
				state_next.rdata = {24'h000000, state_reg.mode};
			end
			else if (s_axi_araddr[3:0] == SSF_ADDR_STATUS && s_axi_araddr[AXI_ADDR_W-1:4] == '0)
			begin
				state_next.rdata = status_word;
			end
			else
			begin
				state_next.rdata = 32'h00000000;
				state_next.rresp = SSF_RESP_SLVERR;
			end
		end
		else if (state_reg.rvalid && s_axi_rready)
		begin
			state_next.rvalid = 1'b0;
		end
	end

	// single state register; packing options start disabled
	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			state_reg <= '0;
			state_reg.tst <= SSF_TX_RESYNC;
			state_reg.rst <= SSF_RX_IDLE;
			state_reg.mode <= SSF_MODE_RESET;
		end
		else
		begin
			state_reg <= state_next;
		end
	end

endmodule // ssf_framer

/* File: ssf_checker.sv */
// concurrent checks on the framer ports
`timescale 1ns/100ps
module ssf_checker (
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// upstream side
	input wire logic src_ready,
	input wire logic src_restart,
	input wire logic up_sync_bit,
	input wire logic [7:0] tx_seq_number,
	input wire logic [7:0] host_seq_confirm,
	// downstream side
	input wire logic [7:0] dn_seq_number,
	input wire logic dn_sync_bit,
	input wire logic dn_sync_ack,
	input wire logic [7:0] rx_seq_confirm,
	input wire logic snk_valid
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);
	// counter steps by one, or reloads from the host after a resync
	seq_step_a: assert property ($changed(tx_seq_number) |->
		tx_seq_number == $past(tx_seq_number) + 8'h01 || tx_seq_number == $past(host_seq_confirm))
		else $error("upstream counter jumped");
	// restart request is a single pulse
	restart_pulse_a: assert property (src_restart |=> !src_restart)
		else $error("restart held too long");
	// a restart always drops synchronisation
	restart_desync_a: assert property ($rose(src_restart) |-> ##[0:1] !up_sync_bit)
		else $error("restart without resync");
	// no bytes taken while unsynchronised
	ready_sync_a: assert property (src_ready |-> up_sync_bit)
		else $error("bytes taken out of sync");
	// sync bit echoed one clock later
	sync_echo_a: assert property ($changed(dn_sync_bit) |=> dn_sync_ack == $past(dn_sync_bit))
		else $error("sync echo wrong");
	// confirmation carries the counter of the window
	confirm_copy_a: assert property ($changed(rx_seq_confirm) |-> rx_seq_confirm == dn_seq_number)
		else $error("confirmation value wrong");
	// confirmation only advances by one while synchronised
	confirm_step_a: assert property ($changed(rx_seq_confirm) && dn_sync_bit && $past(dn_sync_bit)
		|-> rx_seq_confirm == $past(rx_seq_confirm) + 8'h01)
		else $error("confirmation skipped");
	// confirmation only once the window is fully handed on
	confirm_whole_a: assert property ($changed(rx_seq_confirm) && $past(dn_sync_bit) |-> !snk_valid)
		else $error("confirmation before window done");
endmodule // ssf_checker

bind ssf_framer ssf_checker ssf_checker_i (.sys_clk, .reset, .src_ready, .src_restart, .up_sync_bit,
	.tx_seq_number, .host_seq_confirm, .dn_seq_number, .dn_sync_bit, .dn_sync_ack, .rx_seq_confirm,
	.snk_valid);

/* File: ssf_host_model.sv */
// host controller model: bus period ticks, sync handshake, confirmations
`timescale 1ns/100ps
module ssf_host_model #(
	parameter int PERIOD = 16
)(
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// device upstream status
	input wire logic [7:0] tx_seq_number,
	input wire logic up_sync_bit,
	// confirm a sequence not yet sent
	input wire logic ahead,
	// host outputs
	output logic bus_tick,
	output logic [7:0] host_seq_confirm,
	output logic host_up_sync_ack
);
	int cnt;
	// confirm only at a period boundary, after the window was taken whole
	always @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			cnt <= 0;
			bus_tick <= 1'b0;
			host_seq_confirm <= 8'h00;
			host_up_sync_ack <= 1'b0;
		end
		else
		begin
			cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
			bus_tick <= cnt == PERIOD - 1;
			host_up_sync_ack <= up_sync_bit;
			if (bus_tick)
				host_seq_confirm <= tx_seq_number + (ahead ? 8'h05 : 8'h00);
		end
	end
endmodule // ssf_host_model

/* File: tb.sv */
// self-checking bench: registers, upstream framing, downstream parsing
`timescale 1ns/100ps
module tb
	import ssf_pkg::*;
;
	localparam int W = 8;
	logic sys_clk = 0, reset = 1, ahead = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
	logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0, src_valid = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hF;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic src_ready, src_restart, bus_tick, up_sync_bit, host_up_sync_ack, snk_last;
	logic [7:0] src_data = 0, dn_seq_number = 0, last_seq = 0;
	logic [7:0] tx_seq_number, host_seq_confirm, rx_seq_confirm, snk_data;
	logic [15:0] src_remaining = 16'h1, lf = 16'h0010;
	logic [W*8-1:0] upstream_window, dn_window = 0;
	logic dn_sync_bit = 0, dn_sync_ack, snk_valid, snk_ready = 0;
	logic [7:0] mem [2048];
	logic [7:0] wins [$];
	logic [8:0] got [$];
	int mb = 0, me = 0, idx = 0, nx, fails = 0, samples_checked = 0, cyc = 0, rs = 0;

	ssf_framer #(.WIN_BYTES(W), .AXI_ADDR_W(4)) ssf_framer_i (.sys_clk, .reset, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .src_valid, .src_ready, .src_data,
		.src_remaining, .src_restart, .bus_tick, .upstream_window, .tx_seq_number, .up_sync_bit,
		.host_seq_confirm, .host_up_sync_ack, .dn_window, .dn_seq_number, .dn_sync_bit,
		.rx_seq_confirm, .dn_sync_ack, .snk_valid, .snk_ready, .snk_data, .snk_last);
	ssf_host_model #(.PERIOD(16)) ssf_host_model_i (.sys_clk, .reset, .tx_seq_number,
		.up_sync_bit, .ahead, .bus_tick, .host_seq_confirm, .host_up_sync_ack);

	// clock, and a cycle ceiling against hangs
	always #4 sys_clk = ~sys_clk;
	always @(posedge sys_clk)
	begin
		cyc++;
		if (cyc == 40000)
		begin
			fails++;
			results();
		end
	end

	// source replays from its message start on restart; sink stalls at random
	always @(posedge sys_clk)
	begin
		nx = src_restart ? mb : idx + int'(src_valid && src_ready);
		idx <= nx;
		src_valid <= nx < me;
		src_data <= mem[nx];
		src_remaining <= 16'(me - nx);
		snk_ready <= lf[0];
		lf <= nxt(lf);
		if (src_restart)
			rs++;
		if (snk_valid && snk_ready)
			got.push_back({snk_last, snk_data});
		if (up_sync_bit && tx_seq_number === last_seq + 8'h01)
			wins.push_back(upstream_window[7:0]);
		last_seq <= tx_seq_number;
	end

	function automatic logic [15:0] nxt(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction

	// leading control byte of a message in a fresh window
	function automatic logic [7:0] exp_cb(input int len, input logic [1:0] m);
		int l;
		l = m[1] ? 63 : W - 1;
		l = len < l ? len : l;
		return {l == len, m[0], 6'(l)};
	endfunction

	task chk(input logic [31:0] got_v, input logic [31:0] exp_v);
		samples_checked++;
		if (got_v !== exp_v)
		begin
			fails++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got_v, exp_v);
		end
	endtask

	task wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge sys_clk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	task rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge sys_clk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	task wait_ticks(input int n);
		repeat (n) @(posedge sys_clk iff bus_tick);
	endtask

	task wait_win(output logic [7:0] b);
		wins.delete();
		do
			@(posedge sys_clk);
		while (wins.size() == 0 || wins[$] === 8'h00);
		b = wins[$];
	endtask

	// one message upstream; optionally a premature confirmation mid-message
	task up_msg(input logic [1:0] m, input int len, input logic brk);
		logic [1:0] r;
		logic [7:0] b;
		wr(SSF_ADDR_MODE, {30'h0, m}, r);
		wait_ticks(3);
		rs = 0;
		mb <= me;
		me <= me + len;
		wait_win(b);
		chk(32'(b), 32'(exp_cb(len, m)));
		if (brk)
		begin
			ahead <= 1'b1;
			wait_ticks(1);
			ahead <= 1'b0;
			// let the restart pulse reach the source before counting it
			repeat (4) @(posedge sys_clk);
			chk(32'(rs), 32'h1);
			wait_win(b);
			chk(32'(b), 32'(exp_cb(len, m)));
			chk(32'(upstream_window[15:8]), 32'(mem[mb]));
		end
		while (idx != me)
			@(posedge sys_clk);
	endtask

	task dn_send(input logic [7:0] s);
		got.delete();
		@(posedge sys_clk iff bus_tick);
		dn_seq_number <= s;
		dn_sync_bit <= 1'b1;
		dn_window <= {24'h0, mem[2], 8'h81, mem[1], mem[0], 8'h42};
		wait_ticks(3);
	endtask

	task results;
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// main sequence
	initial
	begin
		logic [31:0] d;
		logic [1:0] r;
		for (int i = 0; i < 2048; i++)
		begin
			lf = nxt(lf);
			mem[i] = lf[7:0];
		end
		repeat (8) @(posedge sys_clk);
		reset <= 1'b0;
		rd(SSF_ADDR_MODE, d, r);
		chk(d, 32'h0);
		wr(SSF_ADDR_MODE, 32'hFF, r);
		chk(32'(r), 32'(SSF_RESP_OKAY));
		rd(SSF_ADDR_MODE, d, r);
		chk(d, 32'h3);
		rd(4'hC, d, r);
		chk(32'(r), 32'(SSF_RESP_SLVERR));
		wait_ticks(4);
		chk(32'(wins.size() > 0 && wins[$] === 8'h00), 32'h1);
		up_msg(2'h0, 7, 1'b0);
		up_msg(2'h1, 8, 1'b0);
		up_msg(2'h2, 64, 1'b0);
		up_msg(2'h3, 3, 1'b0);
		repeat (4)
			up_msg(lf[7:6], 1 + int'(lf[5:0]), 1'b0);
		up_msg(2'h0, 30, 1'b1);
		dn_send(8'h01);
		chk(32'(rx_seq_confirm), 32'h1);
		chk(32'(got.size()), 32'h3);
		chk(32'(got[2]), 32'({1'b1, mem[2]}));
		dn_send(8'h03);
		chk(32'(rx_seq_confirm), 32'h1);
		chk(32'(got.size()), 32'h0);
		rd(SSF_ADDR_STATUS, d, r);
		chk(32'(d[0]), 32'h1);
		dn_send(8'h02);
		chk(32'(rx_seq_confirm), 32'h2);
		wr(SSF_ADDR_STATUS, 32'h1, r);
		rd(SSF_ADDR_STATUS, d, r);
		chk(32'(d[0]), 32'h0);
		results();
	end
endmodule // tb
